// [hdl/sxtp_core.sv]
// sxtp_core: scsi-side transfer timing, req/ack pulse shaping and parity.
// assumes an avalon-mm master on ref_clk_in and a synchronous fifo level input.
//
// The register addresses and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/100ps

module sxtp_core
	import sxtp_pkg::*;
#(
	parameter int FIFO_W = 5 // fifo level width
)(
	input  wire logic              ref_clk_in,       // 100 mhz
	input  wire logic              rstn_in,          // sync reset, low
	input  wire logic              clk_en_in,        // freezes state when low
	input  wire logic [7:0]        avs_address_in,   // byte address
	input  wire logic              avs_read_in,      // read strobe
	input  wire logic              avs_write_in,     // write strobe
	input  wire logic [31:0]       avs_writedata_in, // write data
	input  wire logic [3:0]        avs_byteenable_in,// byte lanes
	output logic      [31:0]       avs_readdata_out, // read data
	output wire logic              avs_waitrequest_out, // stall
	input  wire logic [FIFO_W-1:0] fifo_level_in,    // fifo bytes held
	output wire logic              dma_ready_out,    // fifo at threshold
	input  wire logic              sync_mode_in,     // sync transfer active
	input  wire logic              xfer_go_in,       // request next handshake
	output logic                   req_ack_out,      // req/ack, high = asserted
	output logic                   setup_done_out,   // data setup elapsed
	input  wire logic [7:0]        tx_data_in,       // byte to drive
	output logic      [8:0]        tx_bus_out,       // data and parity driven
	input  wire logic [7:0]        rx_data_in,       // received byte
	input  wire logic              rx_parity_in,     // received parity
	input  wire logic              rx_valid_in,      // received byte strobe
	output logic                   rx_parity_out,    // parity kept for rx byte
	output logic                   atn_out,          // atn asserted
	output logic                   par_err_out       // sticky error flag
);

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [7:0]   ctrl1_r;     // control one
	logic [7:0]   ctrl3_r;     // control three
	logic [7:0]   offset_r;    // sync offset, delays
	logic [4:0]   period_r;    // sync period
	logic [2:0]   clkf_r;      // clock conversion factor
	logic [7:0]   cnt_hi_r;    // count high byte
	logic         cnt_loaded_r;// high byte written since reset
	logic         ack_r;       // one-cycle answer pulse
	logic         par_err_r;   // sticky parity error
	logic         atn_r;       // atn driven

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	wire acc      = (avs_read_in | avs_write_in) & clk_en_in;
	wire wr_take  = avs_write_in & ack_r & clk_en_in;
	wire rd_take  = avs_read_in & ack_r & clk_en_in;
	wire be0      = avs_byteenable_in[0];
	wire wr_ctrl1 = wr_take & be0 & (avs_address_in == SXTP_OFS_CTRL1);
	wire wr_ctrl3 = wr_take & be0 & (avs_address_in == SXTP_OFS_CTRL3);
	wire wr_off   = wr_take & be0 & (avs_address_in == SXTP_OFS_OFFSET);
	wire wr_per   = wr_take & be0 & (avs_address_in == SXTP_OFS_PERIOD);
	wire wr_clkf  = wr_take & be0 & (avs_address_in == SXTP_OFS_CLKF);
	wire wr_cnt   = wr_take & be0 & (avs_address_in == SXTP_OFS_CNT_HI);
	wire wr_pclr  = wr_take & be0 & (avs_address_in == SXTP_OFS_PAR_CLR)
	              & avs_writedata_in[SXTP_BIT_PAR_ERR];
	wire rd_stat  = rd_take & (avs_address_in == SXTP_OFS_STATUS);

	// one wait cycle, answer on the second edge
	assign avs_waitrequest_out = ~ack_r;

	// ------------------------------------------------------------
	// timing selection
	// ------------------------------------------------------------
	wire ext_t   = ctrl1_r[SXTP_BIT_EXT_TIMING];
	wire fast_clock_select  = ctrl3_r[SXTP_BIT_FAST_CLK];
	wire fast_timing_select = ctrl3_r[SXTP_BIT_FAST_TIME];
	sxtp_timing_t tsel;

	always_comb begin
		// table lookup from the three mode bits
		if (!fast_clock_select) begin
			tsel.async_setup = ext_t ? SXTP_AS_SLOW_EXT : SXTP_AS_SLOW;
			tsel.sync_setup  = ext_t ? SXTP_SS_SLOW_EXT : SXTP_SS_SLOW;
			tsel.sync_period = ext_t ? SXTP_PER_SLOW_EXT : SXTP_PER_SLOW;
		end else if (!fast_timing_select) begin
			tsel.async_setup = ext_t ? SXTP_AS_FAST_EXT : SXTP_AS_FAST;
			tsel.sync_setup  = SXTP_SS_FAST_CLOCK_SELECT;
			tsel.sync_period = SXTP_PER_FAST_CLOCK_SELECT;
		end else begin
			tsel.async_setup = ext_t ? SXTP_AS_FAST_EXT : SXTP_AS_FAST;
			tsel.sync_setup  = SXTP_SS_FASTBOTH;
			tsel.sync_period = SXTP_PER_FASTBOTH;
		end
	end

	// effective period: larger of table minimum and programmed period
	wire [5:0] prog_per = {1'b0, period_r};
	wire [5:0] min_per  = {2'b00, tsel.sync_period};
	wire [5:0] eff_per  = (prog_per > min_per) ? prog_per : min_per;
	wire [3:0] setup_n  = sync_mode_in ? tsel.sync_setup : tsel.async_setup;

	// delays in half cycles: assert 0..3 halves, deassert -1..+3 halves
	wire [1:0] asrt_dly = offset_r[5:4];
	wire [1:0] dsrt_dly = offset_r[7:6];
	// whole-cycle parts; half cycles are rounded up to a full edge, except deassert with fast clock, which rounds down
	// widened by one bit so that code 3 rounds up to two cycles, not wraps to zero
	wire [1:0] asrt_cyc = 2'(({1'b0, asrt_dly} + 3'd1) >> 1);
	// fast clock: code 0 advances by half (ends one cycle early when possible)
	wire       dsrt_adv = fast_clock_select & (dsrt_dly == 2'd0);
	wire [1:0] dsrt_cyc = fast_clock_select ? 2'(dsrt_dly >> 1)
	                                        : 2'(({1'b0, dsrt_dly} + 3'd1) >> 1);

	// ------------------------------------------------------------
	// req/ack handshake sequencer
	// ------------------------------------------------------------
	typedef enum logic [2:0] {SXTP_IDLE, SXTP_SETUP, SXTP_ADLY, SXTP_HIGH, SXTP_DDLY, SXTP_GAP}
		sxtp_state_t;
	sxtp_state_t st_r, st_nxt;
	logic [5:0]  cnt_r, cnt_nxt;   // cycle counter within state
	logic [5:0]  per_r, per_nxt;   // cycles since leading edge

	always_comb begin
		st_nxt  = st_r;
		cnt_nxt = cnt_r + 6'd1;
		per_nxt = (per_r == 6'h3f) ? per_r : per_r + 6'd1;
		case (st_r)
			SXTP_IDLE: begin
				cnt_nxt = 6'd0;
				if (xfer_go_in) begin
					st_nxt = SXTP_SETUP;
				end
			end
			SXTP_SETUP: begin
				// hold data for the setup minimum, and in sync mode the period
				if (cnt_r + 6'd1 >= {2'b00, setup_n} &&
				    // seven bits: the saturated count must not wrap to zero and stall
				    (!sync_mode_in || ({1'b0, per_r} + 7'd1) >= {1'b0, eff_per})) begin
					st_nxt  = (asrt_cyc == 2'd0) ? SXTP_HIGH : SXTP_ADLY;
					cnt_nxt = 6'd0;
					if (asrt_cyc == 2'd0) begin
						per_nxt = 6'd0;
					end
				end
			end
			SXTP_ADLY: begin
				if (cnt_r + 6'd1 >= {4'h0, asrt_cyc}) begin
					st_nxt  = SXTP_HIGH;
					cnt_nxt = 6'd0;
					per_nxt = 6'd0;
				end
			end
			SXTP_HIGH: begin
				// pulse width one cycle, or none extra when advanced
				st_nxt  = (dsrt_cyc == 2'd0) ? SXTP_GAP : SXTP_DDLY;
				cnt_nxt = 6'd0;
				if (dsrt_adv) begin
					st_nxt = SXTP_GAP;
				end
			end
			SXTP_DDLY: begin
				if (cnt_r + 6'd1 >= {4'h0, dsrt_cyc}) begin
					st_nxt  = SXTP_GAP;
					cnt_nxt = 6'd0;
				end
			end
			SXTP_GAP: begin
				st_nxt  = SXTP_IDLE;
				cnt_nxt = 6'd0;
			end
			default: begin
				st_nxt  = SXTP_IDLE;
				cnt_nxt = 6'd0;
			end
		endcase
	end

	always_ff @(posedge ref_clk_in) begin
		// sequencer state
		if (!rstn_in) begin
			st_r  <= SXTP_IDLE;
			cnt_r <= 6'd0;
			per_r <= 6'h3f;
		end else if (clk_en_in) begin
			st_r  <= st_nxt;
			cnt_r <= cnt_nxt;
			per_r <= per_nxt;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		// registered pin outputs
		if (!rstn_in) begin
			req_ack_out    <= 1'b0;
			setup_done_out <= 1'b0;
		end else if (clk_en_in) begin
			req_ack_out    <= (st_nxt == SXTP_HIGH) | (st_nxt == SXTP_DDLY);
			setup_done_out <= (st_r == SXTP_SETUP) & (st_nxt != SXTP_SETUP);
		end
	end

	// ------------------------------------------------------------
	// fifo threshold to dma
	// ------------------------------------------------------------
	assign dma_ready_out = (fifo_level_in >= FIFO_W'(SXTP_FIFO_THRESH));

	// ------------------------------------------------------------
	// parity
	// ------------------------------------------------------------
	logic tx_par;  // generated for outgoing byte
	logic rx_gen;  // generated for incoming byte

	sxtp_parity u_tx_par (
		.data_in   (tx_data_in),
		.parity_out(tx_par)
	);

	sxtp_parity u_rx_par (
		.data_in   (rx_data_in),
		.parity_out(rx_gen)
	);

	wire chk_en  = ctrl1_r[SXTP_BIT_PAR_CHECK];
	wire bad_par = rx_valid_in & chk_en & (rx_gen != rx_parity_in);

	always_ff @(posedge ref_clk_in) begin
		// outgoing byte always carries generated parity
		if (!rstn_in) begin
			tx_bus_out    <= 9'h000;
			rx_parity_out <= 1'b0;
		end else if (clk_en_in) begin
			tx_bus_out <= {tx_data_in, tx_par};
			if (rx_valid_in) begin
				rx_parity_out <= chk_en ? rx_parity_in : rx_gen;
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		// sticky error flag and atn; a new error beats the clear
		if (!rstn_in) begin
			par_err_r <= 1'b0;
			atn_r     <= 1'b0;
		end else if (clk_en_in) begin
			if (bad_par) begin
				par_err_r <= 1'b1;
				atn_r     <= 1'b1;
			end else if (wr_pclr || rd_stat) begin
				par_err_r <= 1'b0;
				atn_r     <= 1'b0;
			end
		end
	end

	assign atn_out     = atn_r;
	assign par_err_out = par_err_r;

	// ------------------------------------------------------------
	// register writes
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_in) begin
		// software registers
		if (!rstn_in) begin
			ctrl1_r      <= 8'h00;
			ctrl3_r      <= 8'h00;
			offset_r     <= SXTP_RST_OFFSET;
			period_r     <= SXTP_RST_PERIOD;
			clkf_r       <= SXTP_RST_CLKF;
			cnt_hi_r     <= 8'h00;
			cnt_loaded_r <= 1'b0;
			ack_r        <= 1'b0;
		end else if (clk_en_in) begin
			ack_r <= acc & ~ack_r;
			if (wr_ctrl1) ctrl1_r  <= avs_writedata_in[7:0];
			if (wr_ctrl3) ctrl3_r  <= avs_writedata_in[7:0];
			if (wr_off)   offset_r <= avs_writedata_in[7:0];
			if (wr_per)   period_r <= avs_writedata_in[4:0];
			if (wr_clkf)  clkf_r   <= avs_writedata_in[2:0];
			if (wr_cnt) begin
				cnt_hi_r     <= avs_writedata_in[7:0];
				cnt_loaded_r <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------
	wire [7:0] id_or_cnt = cnt_loaded_r ? cnt_hi_r : SXTP_ID_CODE;
	wire [7:0] stat_byte = 8'(par_err_r) << SXTP_BIT_PAR_ERR;
	wire [7:0] tim_byte  = {tsel.async_setup, tsel.sync_setup};
	logic [7:0] rd_byte;

	always_comb begin
		// unmapped addresses read zero
		case (avs_address_in)
			SXTP_OFS_STATUS: rd_byte = stat_byte;
			SXTP_OFS_PERIOD: rd_byte = {3'h0, period_r};
			SXTP_OFS_OFFSET: rd_byte = offset_r;
			SXTP_OFS_CTRL1:  rd_byte = ctrl1_r;
			SXTP_OFS_CLKF:   rd_byte = {5'h00, clkf_r};
			SXTP_OFS_CTRL3:  rd_byte = ctrl3_r;
			SXTP_OFS_CNT_HI: rd_byte = id_or_cnt;
			SXTP_OFS_TIMING: rd_byte = tim_byte;
			default:         rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk_in) begin
		// read data registered, valid while waitrequest low
		if (!rstn_in) begin
			avs_readdata_out <= 32'h0000_0000;
		end else if (clk_en_in) begin
			avs_readdata_out <= {24'h00_0000, (avs_read_in & ~ack_r) ? rd_byte : 8'h00};
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_id_read;
		@(posedge ref_clk_in) disable iff (!rstn_in)
		(rd_take && avs_address_in == SXTP_OFS_CNT_HI && !cnt_loaded_r) |-> avs_readdata_out[7:0] == SXTP_ID_CODE;
	endproperty
	a_id_read: assert property (p_id_read) else $error("id code not read");

	property p_dma;
		@(posedge ref_clk_in) disable iff (!rstn_in)
		dma_ready_out == (fifo_level_in > FIFO_W'(1));
	endproperty
	a_dma: assert property (p_dma) else $error("dma threshold wrong");

	property p_slow_per;
		@(posedge ref_clk_in) disable iff (!rstn_in)
		(!fast_clock_select && !ext_t) |-> tsel.sync_period == 4'h5 && tsel.async_setup == 4'h2;
	endproperty
	a_slow_per: assert property (p_slow_per) else $error("slow timing wrong");

	property p_fast_per;
		@(posedge ref_clk_in) disable iff (!rstn_in)
		(fast_clock_select && !fast_timing_select) |-> tsel.sync_period == 4'h8 && tsel.sync_setup == 4'h3;
	endproperty
	a_fast_per: assert property (p_fast_per) else $error("fast clock timing wrong");

	property p_both_per;
		@(posedge ref_clk_in) disable iff (!rstn_in)
		(fast_clock_select && fast_timing_select && ext_t) |-> tsel.sync_period == 4'h4 && tsel.async_setup == 4'h5;
	endproperty
	a_both_per: assert property (p_both_per) else $error("fast timing wrong");

	property p_tx_odd;
		@(posedge ref_clk_in) disable iff (!rstn_in)
		clk_en_in |=> ^tx_bus_out == 1'b1;
	endproperty
	a_tx_odd: assert property (p_tx_odd) else $error("tx parity not odd");

	property p_perr_set;
		@(posedge ref_clk_in) disable iff (!rstn_in)
		(bad_par && clk_en_in) |=> par_err_out && atn_out;
	endproperty
	a_perr_set: assert property (p_perr_set) else $error("parity error missed");

	property p_perr_hold;
		@(posedge ref_clk_in) disable iff (!rstn_in)
		(par_err_out && !wr_pclr && !rd_stat) |=> par_err_out;
	endproperty
	a_perr_hold: assert property (p_perr_hold) else $error("parity flag dropped");

	property p_nochk;
		@(posedge ref_clk_in) disable iff (!rstn_in)
		(!chk_en && !par_err_out && clk_en_in) |=> !par_err_out;
	endproperty
	a_nochk: assert property (p_nochk) else $error("check while disabled");

endmodule : sxtp_core

// [shared/sxtp_pkg.sv]
// sxtp_pkg: register offsets, field positions, reset values and timing table
// for the scsi transfer timing and parity block.
// assumes a 32-bit avalon-mm slave with byte addresses, one register per word.
//
// Operation
// - identity code readable until high count loaded
// - fifo two bytes signals dma ready
// - slow clock: setup 2/2, period 5; extended 3/3/6
// - fast clock, normal timing: 3(5)/3/8
// - fast clock, fast timing: 3(5)/2/4
// - timing bits from control three and one
// - period register spaces sync req/ack edges
// - offset register holds assert/deassert delays
// - deassert advanced half or delayed upto 1.5
// - assert delayed zero to 1.5 cycles
// - bus parity is odd over nine lines
// - outgoing bytes always get generated parity
// - control one bit 4 enables checking, reset zero
// - bad parity sets status bit 5, asserts atn
// - checking off: parity generated for received bytes
// - reset: offset 0, period 5, clock factor 2

package sxtp_pkg;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] SXTP_OFS_STATUS    = 8'h10; // status read
	localparam logic [7:0] SXTP_OFS_PERIOD    = 8'h18; // sync period write
	localparam logic [7:0] SXTP_OFS_OFFSET    = 8'h1c; // sync offset write
	localparam logic [7:0] SXTP_OFS_CTRL1     = 8'h20; // control one
	localparam logic [7:0] SXTP_OFS_CLKF      = 8'h24; // clock factor write
	localparam logic [7:0] SXTP_OFS_CTRL3     = 8'h30; // control three
	localparam logic [7:0] SXTP_OFS_CNT_HI    = 8'h38; // count high / id
	localparam logic [7:0] SXTP_OFS_TIMING    = 8'h40; // timing readback
	localparam logic [7:0] SXTP_OFS_PAR_CLR   = 8'h44; // parity flag clear

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int SXTP_BIT_EXT_TIMING = 7; // control one
	localparam int SXTP_BIT_PAR_CHECK  = 4; // control one
	localparam int SXTP_BIT_FAST_CLK   = 3; // control three
	localparam int SXTP_BIT_FAST_TIME  = 4; // control three
	localparam int SXTP_BIT_PAR_ERR    = 5; // status

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] SXTP_RST_OFFSET = 8'h00;
	localparam logic [4:0] SXTP_RST_PERIOD = 5'h05;
	localparam logic [2:0] SXTP_RST_CLKF   = 3'h2;
	localparam logic [7:0] SXTP_ID_CODE    = 8'h5a; // arbitrary value

	// ------------------------------------------------------------
	// timing table, cycles
	// ------------------------------------------------------------
	localparam logic [3:0] SXTP_AS_SLOW     = 4'h2;
	localparam logic [3:0] SXTP_AS_SLOW_EXT = 4'h3;
	localparam logic [3:0] SXTP_AS_FAST     = 4'h3;
	localparam logic [3:0] SXTP_AS_FAST_EXT = 4'h5;
	localparam logic [3:0] SXTP_SS_SLOW     = 4'h2;
	localparam logic [3:0] SXTP_SS_SLOW_EXT = 4'h3;
	localparam logic [3:0] SXTP_SS_FAST_CLOCK_SELECT  = 4'h3;
	localparam logic [3:0] SXTP_SS_FASTBOTH = 4'h2;
	localparam logic [3:0] SXTP_PER_SLOW    = 4'h5;
	localparam logic [3:0] SXTP_PER_SLOW_EXT= 4'h6;
	localparam logic [3:0] SXTP_PER_FAST_CLOCK_SELECT = 4'h8;
	localparam logic [3:0] SXTP_PER_FASTBOTH= 4'h4;
	localparam int         SXTP_FIFO_THRESH = 2; // bytes

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [3:0] async_setup;
		logic [3:0] sync_setup;
		logic [3:0] sync_period;
	} sxtp_timing_t;

	typedef struct packed {
		logic [7:0] data;
		logic       parity;
	} sxtp_byte_t;

endpackage : sxtp_pkg

// [hdl/sxtp_parity.sv]
// sxtp_parity: odd parity generator over one byte.
// assumes purely combinational use inside the block.
`timescale 1ns/100ps

module sxtp_parity
	import sxtp_pkg::*;
(
	input  wire logic [7:0] data_in,   // byte
	output wire logic       parity_out // odd parity bit
);

	// ------------------------------------------------------------
	// odd parity: ones across data and parity are odd
	// ------------------------------------------------------------
	assign parity_out = ~(^data_in);

endmodule : sxtp_parity

// [testbench/sxtp_target_model.sv]
// sxtp_target_model: scsi target answering each req/ack pulse with one byte.
// assumes req_ack_in comes from the block under test on the same clock.
`timescale 1ns/100ps

module sxtp_target_model (
	input  wire logic       clk_in,        // bench clock
	input  wire logic       req_ack_in,    // handshake from block
	input  wire logic       bad_par_in,    // bench asks for wrong parity
	input  wire logic [7:0] byte_in,       // byte to return
	output logic      [7:0] rx_data_out,   // data lines
	output logic            rx_parity_out, // parity line
	output logic            rx_valid_out   // byte strobe
);
	logic req_d_r; // last handshake level

	// ------------------------------------------------------------
	// byte return
	// ------------------------------------------------------------
	initial begin
		req_d_r = 1'b0;
		rx_data_out = 8'h00;
		rx_parity_out = 1'b0;
		rx_valid_out = 1'b0;
	end

	// one byte per leading edge, lines scrambled when released
	always @(posedge clk_in) begin
		req_d_r <= req_ack_in;
		rx_valid_out <= req_ack_in & ~req_d_r;
		if (req_ack_in & ~req_d_r) begin
			rx_data_out <= byte_in;
			rx_parity_out <= ~(^byte_in) ^ bad_par_in;
		end else begin
			rx_data_out <= ~rx_data_out; // released lines
			rx_parity_out <= ~rx_parity_out;
		end
	end
endmodule : sxtp_target_model

// [testbench/scsi_xfer_timing_parity_tb.sv]
// scsi_xfer_timing_parity_tb: directed bench for sxtp_core.
// assumes a target model on the far side and one 100 mhz clock.
`timescale 1ns/100ps

`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin mismatches++; \
	$display("Error t=%0t got %h exp %h", $time, (a), (e)); end end

module scsi_xfer_timing_parity_tb;
	import sxtp_pkg::*;
	logic clk = 0, rstn = 0, rd = 0, wr = 0, go = 0, bad = 0, syn = 0; // drives
	logic [7:0] adr = 0, txd = 0, rxd;  // address, bytes
	logic [31:0] wdat = 0, rdat, rv;    // bus data
	logic [4:0] lvl = 0;                // fifo level
	logic wreq, dma, ra, sd, rxp, rxv, rpo, atn, perr; // observed
	logic [8:0] txb;                    // driven bus
	int mismatches = 0, samples_checked = 0;

	always #5 clk = ~clk;

	sxtp_core sxtp_core_inst (.ref_clk_in(clk), .rstn_in(rstn), .clk_en_in(1'b1),
		.avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat),
		.avs_byteenable_in(4'hf), .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
		.fifo_level_in(lvl), .dma_ready_out(dma), .sync_mode_in(syn), .xfer_go_in(go),
		.req_ack_out(ra), .setup_done_out(sd), .tx_data_in(txd), .tx_bus_out(txb),
		.rx_data_in(rxd), .rx_parity_in(rxp), .rx_valid_in(rxv), .rx_parity_out(rpo),
		.atn_out(atn), .par_err_out(perr));
	sxtp_target_model sxtp_target_model_inst (.clk_in(clk), .req_ack_in(ra), .bad_par_in(bad),
		.byte_in(8'h03), .rx_data_out(rxd), .rx_parity_out(rxp), .rx_valid_out(rxv));

	// ------------------------------------------------------------
	// bus cycles and closing
	// ------------------------------------------------------------
	task test_done;
		$display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : test_done

	// one request held until waitrequest seen low
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		adr <= a; wdat <= d; wr <= w; rd <= ~w;
		i = 0;
		do begin @(posedge clk); i++; end while (wreq !== 1'b0 && i < 20);
		if (i >= 20) begin mismatches++; test_done; end
		rv = rdat; wr <= 0; rd <= 0;
	endtask : bus

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task t_reset;
		bus(0, SXTP_OFS_CNT_HI, 0); `CHK(rv[7:0], SXTP_ID_CODE)
		bus(0, SXTP_OFS_CTRL1, 0); `CHK(rv[7:0], 8'h00)
		bus(0, SXTP_OFS_STATUS, 0); `CHK(rv[7:0], 8'h00)
		bus(0, SXTP_OFS_PERIOD, 0); `CHK(rv[4:0], SXTP_RST_PERIOD)
		bus(0, SXTP_OFS_OFFSET, 0); `CHK(rv[7:0], SXTP_RST_OFFSET)
		bus(0, SXTP_OFS_CLKF, 0); `CHK(rv[2:0], SXTP_RST_CLKF)
		bus(1, SXTP_OFS_CNT_HI, 32'h0000_0000);
		bus(0, SXTP_OFS_CNT_HI, 0); `CHK(rv[7:0], 8'h00)
	endtask : t_reset

	// every fast clock, fast timing, extended combination
	task t_timing;
		logic [3:0] as, ss;
		for (int i = 0; i < 8; i++) begin
			bus(1, SXTP_OFS_CTRL1, {24'h0, i[0], 7'h0});
			bus(1, SXTP_OFS_CTRL3, {27'h0, i[2:1], 3'h0});
			as = !i[1] ? (i[0] ? SXTP_AS_SLOW_EXT : SXTP_AS_SLOW) : (i[0] ? SXTP_AS_FAST_EXT : SXTP_AS_FAST);
			ss = !i[1] ? (i[0] ? SXTP_SS_SLOW_EXT : SXTP_SS_SLOW) : (i[2] ? SXTP_SS_FASTBOTH : SXTP_SS_FAST_CLOCK_SELECT);
			bus(0, SXTP_OFS_TIMING, 0); `CHK(rv[7:0], {as, ss})
		end
		bus(1, SXTP_OFS_CLKF, 0);
		bus(1, SXTP_OFS_PERIOD, 32'h04);
		bus(1, SXTP_OFS_CTRL3, 0);
		bus(1, SXTP_OFS_CTRL1, 0);
	endtask : t_timing

	// threshold edge and transmit parity, judged one cycle after each drive
	task t_fifo_tx;
		@(posedge clk); lvl <= 5'h01; txd <= 8'h00;
		@(posedge clk); #1 `CHK(dma, 1'b0)
		`CHK(txb, 9'h001)
		@(posedge clk); lvl <= 5'h02; txd <= 8'h01;
		@(posedge clk); #1 `CHK(dma, 1'b1)
		`CHK(txb, 9'h002)
	endtask : t_fifo_tx

	// one handshake, target returns byte 03h; d extra assert cycles, wx pulse width
	task hs(input logic b, input int d, input int wx);
		int n, w;
		bad <= b;
		@(posedge clk); go <= 1;
		@(posedge clk); go <= 0;
		n = 1;
		while (ra !== 1'b1 && n < 50) begin @(posedge clk); n++; end
		if (n >= 50) begin mismatches++; test_done; end
		`CHK(n, int'(SXTP_AS_SLOW) + 2 + d)
		w = 0;
		while (ra === 1'b1 && w < 10) begin @(posedge clk); w++; end
		`CHK(w, wx)
		repeat (4) @(posedge clk);
	endtask : hs

	task t_parity;
		hs(1, 0, 1); `CHK({rpo, perr, atn}, 3'b100)
		bus(1, SXTP_OFS_CTRL1, 32'h10);
		hs(0, 0, 1); `CHK({rpo, perr}, 2'b10)
		hs(1, 0, 1); `CHK({rpo, perr, atn}, 3'b011)
		repeat (6) @(posedge clk);
		`CHK(perr, 1'b1)
		bus(0, SXTP_OFS_STATUS, 0); `CHK(rv[7:0], 8'h20)
		@(posedge clk); #1 `CHK({perr, atn}, 2'b00)
		hs(1, 0, 1); `CHK(perr, 1'b1)
		bus(1, SXTP_OFS_PAR_CLR, 32'h20);
		@(posedge clk); #1 `CHK({perr, atn}, 2'b00)
	endtask : t_parity

	// sync mode, go held: leading edges spaced by larger of period and table
	task t_sync(input logic [4:0] p, input int ex);
		int n, k;
		bad <= 0;
		bus(1, SXTP_OFS_PERIOD, {27'h0, p});
		syn <= 1; go <= 1;
		n = 0;
		while (ra !== 1'b1 && n < 100) begin @(posedge clk); n++; end
		k = n;
		while (ra !== 1'b0 && n < 100) begin @(posedge clk); n++; end
		while (ra !== 1'b1 && n < 100) begin @(posedge clk); n++; end
		go <= 0; syn <= 0;
		if (n >= 100) begin mismatches++; test_done; end
		`CHK(n - k, ex)
		repeat (8) @(posedge clk);
	endtask : t_sync

	// both delays at their largest code, half cycles rounded up
	task t_delay;
		bus(1, SXTP_OFS_OFFSET, 32'hf0);
		hs(0, 2, 3);
	endtask : t_delay

	// reset pulsed in mid-run brings identity code and defaults back
	task t_midreset;
		@(posedge clk); rstn <= 0;
		repeat (2) @(posedge clk); rstn <= 1;
		t_reset;
	endtask : t_midreset

	initial begin
		repeat (5) @(posedge clk);
		rstn <= 1;
		t_reset;
		t_timing;
		t_fifo_tx;
		t_parity;
		t_midreset;
		t_sync(5'h08, 8);
		t_sync(5'h02, int'(SXTP_PER_SLOW));
		t_delay;
		test_done;
	end
endmodule : scsi_xfer_timing_parity_tb
